/* File: rtl/i2c_line_sampler.sv */
// edge, start and stop detection on the two-wire serial pins
`timescale 1ns/1ps
module i2c_line_sampler (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl,
   input wire logic sda_i,
   output power_warn_pkg::line_ev_t ev
);
   import power_warn_pkg::*;

   // ==========================================
   // previous levels; idle bus reads high
   logic scl_ff;
   logic sda_ff;
   line_ev_t nxt_ev;

   assign nxt_ev.scl_rise = scl & ~scl_ff;
   assign nxt_ev.scl_fall = ~scl & scl_ff;
   // data moving while the clock stays high marks start or stop
   assign nxt_ev.start = scl & scl_ff & sda_ff & ~sda_i;
   assign nxt_ev.stop = scl & scl_ff & ~sda_ff & sda_i;
   assign nxt_ev.sda = sda_i;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scl_ff <= 1'b1;
         sda_ff <= 1'b1;
         ev <= '0;
      end else begin
         scl_ff <= scl;
         sda_ff <= sda_i;
         ev <= nxt_ev;
      end
   end

endmodule // i2c_line_sampler

/* File: rtl/power_warn_pkg.sv */
// shared constants, types and decode functions for the optical power warning thresholds
package power_warn_pkg;

   // ==========================================
   // serial link
   localparam logic [6:0] DEV_ADDR = 7'h51;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ==========================================
   // byte offsets and reset value
   localparam logic [7:0] TX_HI_UPPER_OFS = 8'h1c;
   localparam logic [7:0] TX_HI_LOWER_OFS = 8'h1d;
   localparam logic [7:0] TX_LO_UPPER_OFS = 8'h1e;
   localparam logic [7:0] TX_LO_LOWER_OFS = 8'h1f;
   localparam logic [7:0] RX_HI_UPPER_OFS = 8'h24;
   localparam logic [7:0] RX_HI_LOWER_OFS = 8'h25;
   localparam logic [7:0] RX_LO_UPPER_OFS = 8'h26;
   localparam logic [7:0] RX_LO_LOWER_OFS = 8'h27;
   localparam logic [7:0] THR_RESET = 8'h00;
   localparam int THR_COUNT = 8;

   // ==========================================
   // storage index of each byte
   localparam logic [2:0] IDX_TX_HI_UPPER = 3'h0;
   localparam logic [2:0] IDX_TX_HI_LOWER = 3'h1;
   localparam logic [2:0] IDX_TX_LO_UPPER = 3'h2;
   localparam logic [2:0] IDX_TX_LO_LOWER = 3'h3;
   localparam logic [2:0] IDX_RX_HI_UPPER = 3'h4;
   localparam logic [2:0] IDX_RX_HI_LOWER = 3'h5;
   localparam logic [2:0] IDX_RX_LO_UPPER = 3'h6;
   localparam logic [2:0] IDX_RX_LO_LOWER = 3'h7;

   // ==========================================
   // weights, in nanowatts per bit
   localparam int UPPER_LSB_NW = 25600;
   localparam int LOWER_LSB_NW = 100;

   // ==========================================
   // types
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_ADDR = 4'b0001,
      ST_ADDR_ACK = 4'b0010,
      ST_PTR = 4'b0011,
      ST_PTR_ACK = 4'b0100,
      ST_WR = 4'b0101,
      ST_WR_ACK = 4'b0110,
      ST_RD = 4'b0111,
      ST_RD_ACK = 4'b1000
   } link_state_t;

   typedef struct packed {
      logic [7:0] tx_upper;
      logic [7:0] rx_upper;
   } meas_t;

   typedef struct packed {
      logic tx_hi;
      logic tx_lo;
      logic rx_hi;
      logic rx_lo;
   } warn_flags_t;

   typedef struct packed {
      logic [7:0] tx_hi;
      logic [7:0] tx_lo;
      logic [7:0] rx_hi;
      logic [7:0] rx_lo;
   } thr_upper_t;

   typedef struct packed {
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
      logic sda;
   } line_ev_t;

   // ==========================================
   // decode
   function automatic logic reg_hit(input logic [7:0] addr);
      return (addr[7:2] == TX_HI_UPPER_OFS[7:2]) || (addr[7:2] == RX_HI_UPPER_OFS[7:2]);
   endfunction

   // the two banks differ in bit 3, the byte within a bank in bits 1:0
   function automatic logic [2:0] reg_idx(input logic [7:0] addr);
      return {~addr[3], addr[1:0]};
   endfunction

endpackage

/* File: rtl/power_warn_thresholds.sv */
// optical power warning threshold bytes behind a two-wire serial slave
//
// What this block does
// - tx high threshold upper byte, 25.6 uW per bit, pairs with lower byte
// - tx high warning set when measured tx upper byte exceeds threshold upper byte
// - tx low threshold upper byte, 25.6 uW per bit, pairs with lower byte
// - tx low warning set when measured tx upper byte is below threshold upper byte
// - rx high threshold upper byte, 25.6 uW per bit, pairs with lower byte
// - rx high warning set when measured rx upper byte exceeds threshold upper byte
// - lower bytes, 0.1 uW per bit, read and write but never compared
// - thresholds are raw codes, compared directly; host converts limits first
// - rx low warning set when measured rx upper byte is below threshold upper byte
`timescale 1ns/1ps
module power_warn_thresholds (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   input power_warn_pkg::meas_t meas,
   input wire logic meas_valid,
   output power_warn_pkg::warn_flags_t flags
);
   import power_warn_pkg::*;

   // ==========================================
   // state
   line_ev_t ev;
   link_state_t st_ff;
   link_state_t nxt_st;
   logic [7:0] sh_ff;
   logic [7:0] nxt_sh;
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   logic rw_ff;
   logic nxt_rw;
   logic [7:0] ptr_ff;
   logic [7:0] nxt_ptr;
   logic drive_ff;
   logic nxt_drive;
   logic mack_ff;
   logic nxt_mack;
   logic [7:0] thr_ff [THR_COUNT];
   thr_upper_t thr_up;

   // ==========================================
   // decode
   wire logic byte_done = ev.scl_fall && (cnt_ff == BITS_PER_BYTE);
   wire logic [7:0] sh_in = {sh_ff[6:0], ev.sda};
   wire logic [3:0] cnt_inc = cnt_ff + 4'h1;
   wire logic [7:0] ptr_inc = ptr_ff + 8'h1;
   wire logic ptr_hit = reg_hit(ptr_ff);
   wire logic [2:0] ptr_idx = reg_idx(ptr_ff);
   // unmapped pointers still ack, read as zero and drop writes
   wire logic [7:0] rd_byte = ptr_hit ? thr_ff[ptr_idx] : UNMAPPED_READ;
   wire logic wr_pulse = (st_ff == ST_WR) && byte_done && ptr_hit;
   wire logic addr_match = sh_ff[7:1] == DEV_ADDR;

   i2c_line_sampler u_line (
      .clk(clk),
      .nrst(nrst),
      .scl(scl),
      .sda_i(sda_i),
      .ev(ev)
   );

   // ==========================================
   // serial protocol
   // sda is only driven or changed after a detected clock fall (a start or stop only releases it), so the master must keep
   // scl low for at least three clock periods
   always_comb begin
      nxt_st = st_ff;
      nxt_sh = sh_ff;
      nxt_cnt = cnt_ff;
      nxt_rw = rw_ff;
      nxt_ptr = ptr_ff;
      nxt_drive = drive_ff;
      nxt_mack = mack_ff;
      if (ev.stop) begin
         nxt_st = ST_IDLE;
         nxt_drive = 1'b0;
      end else if (ev.start) begin
         // a repeated start keeps the pointer for a following read
         nxt_st = ST_ADDR;
         nxt_cnt = 4'h0;
         nxt_drive = 1'b0;
      end else begin
         case (st_ff)
            ST_ADDR: begin
               if (ev.scl_rise) begin
                  nxt_sh = sh_in;
                  nxt_cnt = cnt_inc;
               end else if (byte_done) begin
                  if (addr_match) begin
                     nxt_rw = sh_ff[0];
                     nxt_drive = 1'b1;
                     nxt_st = ST_ADDR_ACK;
                  end else begin
                     nxt_st = ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (ev.scl_fall) begin
                  nxt_cnt = 4'h0;
                  if (rw_ff) begin
                     nxt_sh = rd_byte;
                     nxt_drive = ~rd_byte[7];
                     nxt_st = ST_RD;
                  end else begin
                     nxt_drive = 1'b0;
                     nxt_st = ST_PTR;
                  end
               end
            end
            ST_PTR: begin
               if (ev.scl_rise) begin
                  nxt_sh = sh_in;
                  nxt_cnt = cnt_inc;
               end else if (byte_done) begin
                  nxt_ptr = sh_ff;
                  nxt_drive = 1'b1;
                  nxt_st = ST_PTR_ACK;
               end
            end
            ST_PTR_ACK, ST_WR_ACK: begin
               if (ev.scl_fall) begin
                  nxt_drive = 1'b0;
                  nxt_cnt = 4'h0;
                  nxt_st = ST_WR;
               end
            end
            ST_WR: begin
               if (ev.scl_rise) begin
                  nxt_sh = sh_in;
                  nxt_cnt = cnt_inc;
               end else if (byte_done) begin
                  nxt_ptr = ptr_inc;
                  nxt_drive = 1'b1;
                  nxt_st = ST_WR_ACK;
               end
            end
            ST_RD: begin
               if (ev.scl_rise) begin
                  nxt_cnt = cnt_inc;
               end else if (byte_done) begin
                  nxt_drive = 1'b0;
                  nxt_ptr = ptr_inc;
                  nxt_st = ST_RD_ACK;
               end else if (ev.scl_fall && cnt_ff != 4'h0) begin
                  nxt_sh = {sh_ff[6:0], 1'b0};
                  nxt_drive = ~sh_ff[6];
               end
            end
            ST_RD_ACK: begin
               if (ev.scl_rise) begin
                  nxt_mack = ev.sda;
               end else if (ev.scl_fall) begin
                  if (!mack_ff) begin
                     nxt_sh = rd_byte;
                     nxt_drive = ~rd_byte[7];
                     nxt_cnt = 4'h0;
                     nxt_st = ST_RD;
                  end else begin
                     nxt_st = ST_IDLE;
                  end
               end
            end
            default: begin
               nxt_st = st_ff;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_ff <= ST_IDLE;
         sh_ff <= 8'h00;
         cnt_ff <= 4'h0;
         rw_ff <= 1'b0;
         ptr_ff <= 8'h00;
         drive_ff <= 1'b0;
         mack_ff <= 1'b1;
      end else begin
         st_ff <= nxt_st;
         sh_ff <= nxt_sh;
         cnt_ff <= nxt_cnt;
         rw_ff <= nxt_rw;
         ptr_ff <= nxt_ptr;
         drive_ff <= nxt_drive;
         mack_ff <= nxt_mack;
      end
   end

   // open drain: only ever pull low
   assign sda_o = 1'b0;
   assign sda_oe_n = ~drive_ff;

   // ==========================================
   // threshold bytes; all eight are plain read/write storage
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < THR_COUNT; i++) begin
            thr_ff[i] <= THR_RESET;
         end
      end else if (wr_pulse) begin
         thr_ff[ptr_idx] <= sh_ff;
      end
   end

   // only the upper bytes reach the compare; lower bytes stay out of it
   assign thr_up.tx_hi = thr_ff[IDX_TX_HI_UPPER];
   assign thr_up.tx_lo = thr_ff[IDX_TX_LO_UPPER];
   assign thr_up.rx_hi = thr_ff[IDX_RX_HI_UPPER];
   assign thr_up.rx_lo = thr_ff[IDX_RX_LO_UPPER];

   warn_compare u_cmp (
      .clk(clk),
      .nrst(nrst),
      .meas(meas),
      .meas_valid(meas_valid),
      .thr(thr_up),
      .flags(flags)
   );

   // ==========================================
   // checks
   a_tx_hi_store: assert property (@(posedge clk) disable iff (!nrst)
      (wr_pulse && ptr_idx == IDX_TX_HI_UPPER) |=> thr_ff[IDX_TX_HI_UPPER] == $past(sh_ff))
      else $error("tx high upper byte not stored");
   a_tx_lo_store: assert property (@(posedge clk) disable iff (!nrst)
      (wr_pulse && ptr_idx == IDX_TX_LO_UPPER) |=> thr_up.tx_lo == $past(sh_ff))
      else $error("tx low upper byte not stored");
   a_rx_hi_store: assert property (@(posedge clk) disable iff (!nrst)
      (wr_pulse && ptr_idx == IDX_RX_HI_UPPER) |=> thr_up.rx_hi == $past(sh_ff))
      else $error("rx high upper byte not stored");
   a_lower_kept: assert property (@(posedge clk) disable iff (!nrst)
      (wr_pulse && ptr_idx == IDX_TX_HI_LOWER) |=> thr_ff[IDX_TX_HI_LOWER] == $past(sh_ff)
      && $stable(thr_up))
      else $error("lower byte not stored or leaked into compare");
   a_ack_drive: assert property (@(posedge clk) disable iff (!nrst)
      (st_ff == ST_ADDR && byte_done && addr_match) |=> !sda_oe_n [*2])
      else $error("address ack not driven");

   // ==========================================
   // checks: threshold storage
   a_rx_lo_store: assert property (@(posedge clk) disable iff (!nrst)
      (wr_pulse && ptr_idx == IDX_RX_LO_UPPER) |=> thr_up.rx_lo == $past(sh_ff))
      else $error("rx low upper byte not stored");
   // every lower byte sits at an odd index, so bit 0 alone marks it
   a_lower_apart: assert property (@(posedge clk) disable iff (!nrst)
      (wr_pulse && ptr_idx[0]) |=> $stable(thr_up))
      else $error("lower byte write moved a compared threshold");
   a_thr_hold: assert property (@(posedge clk) disable iff (!nrst)
      !wr_pulse |=> $stable(thr_up))
      else $error("threshold changed without a write");

   // ==========================================
   // checks: pointer and write path
   a_ptr_load: assert property (@(posedge clk) disable iff (!nrst)
      (st_ff == ST_PTR && byte_done) |=> ptr_ff == $past(sh_ff))
      else $error("pointer byte not loaded");
   a_ptr_ack: assert property (@(posedge clk) disable iff (!nrst)
      (st_ff == ST_PTR && byte_done) |=> !sda_oe_n [*2])
      else $error("pointer ack not driven");
   a_ack_release: assert property (@(posedge clk) disable iff (!nrst)
      (st_ff == ST_PTR_ACK && ev.scl_fall) |=> sda_oe_n && st_ff == ST_WR)
      else $error("pointer ack not released");
   a_ptr_step: assert property (@(posedge clk) disable iff (!nrst)
      (st_ff == ST_WR && byte_done) |=> ptr_ff == $past(ptr_ff) + 8'h01)
      else $error("pointer did not step after a data byte");
   a_wr_ack: assert property (@(posedge clk) disable iff (!nrst)
      (st_ff == ST_WR && byte_done) |=> !sda_oe_n [*2])
      else $error("data ack not driven");

   // ==========================================
   // checks: read path and bus framing
   // the first data bit goes out on the ack fall, before any rise is counted
   a_rd_first: assert property (@(posedge clk) disable iff (!nrst)
      (st_ff == ST_ADDR_ACK && ev.scl_fall && rw_ff) |=> sda_oe_n == $past(rd_byte[7]))
      else $error("first read bit wrong");
   a_rd_shift: assert property (@(posedge clk) disable iff (!nrst)
      (st_ff == ST_RD && ev.scl_fall && !byte_done && cnt_ff != 4'h0)
      |=> sda_oe_n == $past(sh_ff[6]))
      else $error("read bit not shifted out");
   a_rd_release: assert property (@(posedge clk) disable iff (!nrst)
      (st_ff == ST_RD && byte_done) |=> sda_oe_n && st_ff == ST_RD_ACK)
      else $error("line not released for host ack");
   a_mack_take: assert property (@(posedge clk) disable iff (!nrst)
      (st_ff == ST_RD_ACK && ev.scl_rise) |=> mack_ff == $past(ev.sda))
      else $error("host ack not sampled");
   a_nack_end: assert property (@(posedge clk) disable iff (!nrst)
      (st_ff == ST_RD_ACK && ev.scl_fall && mack_ff) |=> st_ff == ST_IDLE)
      else $error("read went on after host nack");
   // a refused address must leave the line free for whoever is addressed
   a_bad_addr: assert property (@(posedge clk) disable iff (!nrst)
      (st_ff == ST_ADDR && byte_done && !addr_match) |=> st_ff == ST_IDLE && sda_oe_n)
      else $error("foreign address not ignored");
   a_start_addr: assert property (@(posedge clk) disable iff (!nrst)
      ev.start |=> st_ff == ST_ADDR && cnt_ff == 4'h0 && sda_oe_n)
      else $error("start did not open an address byte");
   a_stop_idle: assert property (@(posedge clk) disable iff (!nrst)
      ev.stop |=> st_ff == ST_IDLE && sda_oe_n)
      else $error("stop did not free the line");

endmodule // power_warn_thresholds

/* File: rtl/warn_compare.sv */
// upper-byte magnitude compares that drive the four warning flags
`timescale 1ns/1ps
module warn_compare (
   input wire logic clk,
   input wire logic nrst,
   input power_warn_pkg::meas_t meas,
   input wire logic meas_valid,
   input power_warn_pkg::thr_upper_t thr,
   output power_warn_pkg::warn_flags_t flags
);
   import power_warn_pkg::*;

   // ==========================================
   // compares on raw codes, no calibration applied
   warn_flags_t cmp;

   assign cmp.tx_hi = meas.tx_upper > thr.tx_hi;
   assign cmp.tx_lo = meas.tx_upper < thr.tx_lo;
   assign cmp.rx_hi = meas.rx_upper > thr.rx_hi;
   assign cmp.rx_lo = meas.rx_upper < thr.rx_lo;

   // flags follow the latest result, they are not sticky here
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flags <= '0;
      end else if (meas_valid) begin
         flags <= cmp;
      end
   end

   // ==========================================
   // checks
   a_tx_hi_flag: assert property (@(posedge clk) disable iff (!nrst)
      meas_valid |=> flags.tx_hi == ($past(meas.tx_upper) > $past(thr.tx_hi)))
      else $error("tx high warning does not match compare");
   a_tx_lo_flag: assert property (@(posedge clk) disable iff (!nrst)
      meas_valid |=> flags.tx_lo == ($past(meas.tx_upper) < $past(thr.tx_lo)))
      else $error("tx low warning does not match compare");
   a_rx_hi_flag: assert property (@(posedge clk) disable iff (!nrst)
      meas_valid |=> flags.rx_hi == ($past(meas.rx_upper) > $past(thr.rx_hi)))
      else $error("rx high warning does not match compare");
   a_rx_lo_flag: assert property (@(posedge clk) disable iff (!nrst)
      meas_valid |=> flags.rx_lo == ($past(meas.rx_upper) < $past(thr.rx_lo)))
      else $error("rx low warning does not match compare");
   a_flag_hold: assert property (@(posedge clk) disable iff (!nrst)
      !meas_valid |=> $stable(flags))
      else $error("warning flags changed without a new result");
   a_raw_equal: assert property (@(posedge clk) disable iff (!nrst)
      (meas_valid && meas.tx_upper == thr.tx_hi && meas.rx_upper == thr.rx_lo)
      |=> !flags.tx_hi && !flags.rx_lo)
      else $error("equal raw code raised a warning");

endmodule // warn_compare

/* File: verif/power_warn_thresholds_tb.sv */
// self-checking bench for the optical power warning threshold bytes
`timescale 1ns/1ps
module power_warn_thresholds_tb;
   import power_warn_pkg::*;
   localparam logic [7:0] OFS [4] = '{TX_HI_UPPER_OFS, TX_LO_UPPER_OFS,
                                      RX_HI_UPPER_OFS, RX_LO_UPPER_OFS};
   logic clk;
   logic nrst;
   logic scl;
   logic sda_drv;
   logic sda_line;
   logic sda_o;
   logic sda_oe_n;
   meas_t meas;
   logic meas_valid;
   warn_flags_t flags;
   logic res_valid;
   logic [15:0] res_data;
   logic mv_d;
   int failures;
   int compares;
   int cycles;
   int seed;
   logic [7:0] thr [4];
   logic [15:0] exp_bus [$];
   warn_flags_t exp_flag [$];
   // ==========================================
   // open-drain wire with pull-up
   assign sda_line = sda_drv & (sda_oe_n | sda_o);
   power_warn_thresholds u_power_warn_thresholds (.clk(clk), .nrst(nrst), .scl(scl),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .meas(meas),
      .meas_valid(meas_valid), .flags(flags));
   two_wire_host u_two_wire_host (.clk(clk), .scl(scl), .sda_drv(sda_drv),
      .sda_line(sda_line), .res_valid(res_valid), .res_data(res_data));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ==========================================
   // checking
   task automatic summarize();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // flags land at the valid edge, so they are read one edge later
   always @(posedge clk) begin
      mv_d <= meas_valid;
      cycles++;
      if (res_valid === 1'b1)
         check("bus result", exp_bus.size() > 0 ? exp_bus.pop_front() : 16'hxxxx,
               res_data);
      if (mv_d === 1'b1 && exp_flag.size() > 0)
         check("flags", {12'h000, exp_flag.pop_front()}, {12'h000, flags});
      if (cycles == 60000) begin
         failures++;
         summarize();
      end
   end
   // ==========================================
   // stimulus
   function automatic warn_flags_t exp_of(input meas_t m);
      return {m.tx_upper > thr[0], m.tx_upper < thr[1], m.rx_upper > thr[2],
              m.rx_upper < thr[3]};
   endfunction
   task automatic rd(input logic [7:0] ptr, input logic [15:0] e);
      exp_bus.push_back(e);
      u_two_wire_host.read16(ptr);
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
      exp_bus.push_back(16'h0001);
      u_two_wire_host.write16(ptr, d);
   endtask
   task automatic set_thr(input int i, input logic [7:0] up, input logic [7:0] lo);
      thr[i] = up;
      wr(OFS[i], {up, lo});
   endtask
   // valid stays high when the next pulse follows at once
   task automatic pulse(input meas_t m, input logic last);
      meas <= m;
      meas_valid <= 1'b1;
      exp_flag.push_back(exp_of(m));
      @(posedge clk);
      if (last) begin
         meas_valid <= 1'b0;
         @(posedge clk);
      end
   endtask
   initial begin
      seed = 43;
      nrst = 1'b0;
      meas = 16'h0000;
      meas_valid = 1'b0;
      mv_d = 1'b0;
      failures = 0;
      compares = 0;
      cycles = 0;
      thr = '{default: 8'h00};
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (OFS[i]) rd(OFS[i], 16'h0000);
      exp_bus.push_back(16'h0000);
      u_two_wire_host.probe(DEV_ADDR ^ 7'h01);
      exp_bus.push_back(16'h0001);
      u_two_wire_host.probe(DEV_ADDR);
      set_thr(0, u_two_wire_host.raw_upper(3276800), 8'h00);
      set_thr(1, 8'h40, 8'h5a);
      set_thr(2, 8'hc0, 8'h00);
      set_thr(3, 8'h20, 8'hff);
      rd(8'h1c, 16'h8000);
      rd(8'h1f, 16'h5a00);
      rd(8'h26, 16'h20ff);
      wr(8'h20, 16'ha5a5);
      rd(8'h20, 16'h0000);
      // equal raises nothing, one code past the threshold does, one code short of it does not
      foreach (thr[k])
         for (int d = -1; d <= 1; d++)
            pulse(k < 2 ? {8'(thr[k] + d), 8'h80} : {8'h60, 8'(thr[k] + d)},
                  d == 1);
      pulse({thr[0], thr[3]}, 1'b1);
      repeat (3) begin
         foreach (thr[k]) set_thr(k, 8'($random(seed)), 8'h00);
         repeat (12) pulse(meas_t'(16'($random(seed))), 1'($random(seed)));
         pulse(meas_t'(16'($random(seed))), 1'b1);
      end
      // leave flags raised so that the reset below has something to clear
      pulse({8'hff, 8'h00}, 1'b1);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      check("flags in reset", 16'h0000, {12'h000, flags});
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      rd(OFS[0], 16'h0000);
      repeat (20) @(posedge clk);
      if (exp_bus.size() + exp_flag.size() != 0)
         failures++;
      summarize();
   end
endmodule // power_warn_thresholds_tb

/* File: verif/two_wire_host.sv */
// behavioural two-wire host that writes and reads the threshold bytes
`timescale 1ns/1ps
module two_wire_host (
   input wire logic clk,
   output logic scl,
   output logic sda_drv,
   input wire logic sda_line,
   output logic res_valid,
   output logic [15:0] res_data
);
   import power_warn_pkg::*;
   // ==========================================
   // line phases: 8 clk a half bit keeps both scl phases above the 3 clk floor
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
      res_valid = 1'b0;
      res_data = 16'h0000;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic start_bit();
      sda_drv <= 1'b0;
      tick(8);
      scl <= 1'b0;
   endtask
   task automatic restart_bit();
      tick(4);
      sda_drv <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(8);
      start_bit();
   endtask
   task automatic stop_bit();
      tick(4);
      sda_drv <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(8);
      sda_drv <= 1'b1;
      tick(8);
   endtask
   // data moves 4 clk after the fall, never while scl is high
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         tick(4);
         sda_drv <= b[i];
         tick(4);
         scl <= 1'b1;
         tick(8);
         scl <= 1'b0;
      end
      tick(4);
      sda_drv <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(4);
      ack = ~sda_line;
      tick(4);
      scl <= 1'b0;
   endtask
   task automatic recv_byte(input logic last, output logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         tick(4);
         sda_drv <= 1'b1;
         tick(4);
         scl <= 1'b1;
         tick(4);
         b[i] = sda_line;
         tick(4);
         scl <= 1'b0;
      end
      tick(4);
      sda_drv <= last;
      tick(4);
      scl <= 1'b1;
      tick(8);
      scl <= 1'b0;
   endtask
   task automatic post(input logic [15:0] d);
      res_data <= d;
      res_valid <= 1'b1;
      tick(1);
      res_valid <= 1'b0;
   endtask
   // ==========================================
   // transactions; each ends with one result pulse
   task automatic probe(input logic [6:0] addr);
      logic a;
      start_bit();
      send_byte({addr, 1'b0}, a);
      stop_bit();
      post({15'h0000, a});
   endtask
   task automatic write16(input logic [7:0] ptr, input logic [15:0] d);
      logic a;
      logic ok;
      start_bit();
      send_byte({DEV_ADDR, 1'b0}, ok);
      send_byte(ptr, a);
      ok = ok & a;
      send_byte(d[15:8], a);
      ok = ok & a;
      send_byte(d[7:0], a);
      stop_bit();
      post({15'h0000, ok & a});
   endtask
   task automatic read16(input logic [7:0] ptr);
      logic a;
      logic [7:0] hi;
      logic [7:0] lo;
      start_bit();
      send_byte({DEV_ADDR, 1'b0}, a);
      send_byte(ptr, a);
      restart_bit();
      send_byte({DEV_ADDR, 1'b1}, a);
      recv_byte(1'b0, hi);
      recv_byte(1'b1, lo);
      stop_bit();
      post({hi, lo});
   endtask
   // limits arrive in nanowatts; the device only compares raw codes
   function automatic logic [7:0] raw_upper(input int nw);
      return 8'(nw / UPPER_LSB_NW);
   endfunction
endmodule // two_wire_host
